/* File: design/aofm_defs.vh */
// constants for the adc output format and multiplex block
// assumes plain verilog-2005, included by bare name
`ifndef AOFM_DEFS_VH
`define AOFM_DEFS_VH
`define AOFM_W 11
`define AOFM_POS_FS_OB 11'h7FF
`define AOFM_POS_FS_TC 11'h3FF
`define AOFM_NEG_FS_OB 11'h000
`define AOFM_NEG_FS_TC 11'h400
`define AOFM_MSB_FLIP 11'h400
`define AOFM_ZERO 11'h000
`define AOFM_MUX_CODE 3'h7
`define AOFM_FIFO_DEPTH 32
`define AOFM_FIFO_AW 5
`define AOFM_PH_A 1'b0
`define AOFM_PH_B 1'b1
`endif

/* File: design/aofm_fifo.v */
// parameterised flip-flop fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset
module aofm_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    // storage, indexed by pointer
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    // full count and last index, sized on purpose for the compares below
    localparam integer DEPTH_I = DEPTH;
    localparam integer LAST_I = DEPTH - 1;
    assign in_ready = (cnt_q != DEPTH_I[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_q];
    // pointer and count update
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : rd_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
    // data write, no reset needed on storage
    always @(posedge sys_clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
endmodule

/* File: design/aofm_top.v */
// output formatting and multiplexing of a dual 11-bit converter
// assumes raw samples arrive as offset binary with over/under flags,
// on sys_clk; the receiver latches on the rising edge of the out clock
// assumes the mode field input comes from logic on sys_clk, while the
// three config pins come straight from the board and are filtered here
// assumes the system keeps mux mode to sampling rates under 75 MSPS;
// nothing here can tell the rate, so it is not checked
`include "aofm_defs.vh"

// Operation
// - mux mode: both channels on B bus
// - mux mode: A pins driven low
// - mux from power field or pins
// - per channel twos or offset coding
// - positive overdrive gives positive full scale
// - negative overdrive gives negative full scale
// - 11-bit words plus common out clock
// - one word per out clock cycle
module aofm_top #(
    parameter W = `AOFM_W,
    parameter DEPTH = `AOFM_FIFO_DEPTH
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // raw sample pair with overdrive flags
    input wire [W-1:0] raw_a,
    input wire ovr_pos_a,
    input wire ovr_neg_a,
    input wire [W-1:0] raw_b,
    input wire ovr_pos_b,
    input wire ovr_neg_b,
    // pair handshake toward the converter core
    input wire samp_valid,
    output wire samp_ready,
    // per channel coding select, 1 for twos complement
    input wire per_channel_code_format_a,
    input wire per_channel_code_format_b,
    // mode select sources
    input wire mux_reg_en,
    input wire [2:0] ctrl_pins,
    // output pins toward the receiver
    output reg [W-1:0] chan_a_out_pins,
    output wire [W-1:0] chan_a_out_oe,
    output reg [W-1:0] chan_b_out_bus,
    output reg sample_out_clock
);
    // pin synchroniser, three stages; the first may go metastable,
    // so only the second stage ever reads it
    reg [2:0] pin_s1_q; // first stage, raw capture
    reg [2:0] pin_s2_q; // second stage, settled
    reg [2:0] pin_s3_q; // third stage, agree check
    reg [2:0] pin_q; // filtered pin value in use
    // formatted words and fifo wiring
    // the pair travels as one word: A in the upper half, B in the lower
    wire [W-1:0] fmt_a;
    wire [W-1:0] fmt_b;
    wire [2*W-1:0] ff_out;
    wire ff_valid;
    wire ff_ready;
    // output phase and mux state
    reg ph_q; // which word of a mux pair is next
    reg hi_q; // out clock phase, 1 on the cycle before a new word
    reg mux_q; // mode in force, changed only between pairs
    wire mux_req; // mode asked for by field or pins

    // per channel coding and overdrive clamp
    // twos complement is offset binary with the msb inverted, so one
    // xor does the conversion; positive overdrive wins if both flags
    function [W-1:0] fmt;
        input [W-1:0] raw;
        input pos;
        input neg;
        input twos;
        begin
            if (pos)
                fmt = twos ? `AOFM_POS_FS_TC : `AOFM_POS_FS_OB;
            else if (neg)
                fmt = twos ? `AOFM_NEG_FS_TC : `AOFM_NEG_FS_OB;
            else
                fmt = twos ? (raw ^ `AOFM_MSB_FLIP) : raw;
        end
    endfunction

    assign fmt_a = fmt(raw_a, ovr_pos_a, ovr_neg_a, per_channel_code_format_a);
    assign fmt_b = fmt(raw_b, ovr_pos_b, ovr_neg_b, per_channel_code_format_b);

    // sample buffer; source stalls via samp_ready when full
    // a pair enters as one word so the two channels never slip apart;
    // coding is fixed at entry, so a format change applies to new pairs
    aofm_fifo #(
        .WIDTH(2*W),
        .DEPTH(DEPTH),
        .AW(`AOFM_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_data({fmt_a, fmt_b}),
        .in_valid(samp_valid),
        .in_ready(samp_ready),
        .out_data(ff_out),
        .out_valid(ff_valid),
        .out_ready(ff_ready)
    );

    // pins change only once stages two and three agree
    // reset clears the chain, so the pins read as 0 until filtered
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
            pin_q <= 3'h0;
        end
        else
        begin
            pin_s1_q <= ctrl_pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // filter: a one-cycle glitch never reaches pin_q
            if (pin_s2_q == pin_s3_q)
                pin_q <= pin_s3_q;
        end
    end

    // pin code all ones selects mux; other pin codes leave it to the field
    // either source enables
    assign mux_req = mux_reg_en | (pin_q == `AOFM_MUX_CODE);

    // out clock runs at half sys_clk: data set on low phase, latched on rise
    // in mux mode a pair takes two out clocks, halving sample throughput
    // popping on the launch cycle keeps ff_out stable while it is shown
    assign ff_ready = hi_q & ((~mux_q) | (ph_q == `AOFM_PH_B));

    // output driver; a mode change is taken only between pairs
    // schedule, one out clock period = two sys_clk cycles:
    //   hi_q 0 -> 1: out clock rises, receiver latches the standing word
    //   hi_q 1 -> 0: out clock falls, the next word is launched
    // normal mode: A and B words launch together, one pair per period
    // mux mode: A word in one period, B word in the next, both on the
    // B bus; the fifo pops only with the B word, so a stall between
    // the two words cannot split a pair
    // when the fifo runs dry the outputs simply hold; the receiver sees
    // a repeated word, which is the price of keeping the clock running
    // a mode change mid-pair would leave the receiver out of step,
    // hence the change waits for the B word or an idle A phase
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hi_q <= 1'b0;
            ph_q <= `AOFM_PH_A;
            mux_q <= 1'b0;
            sample_out_clock <= 1'b0;
            chan_a_out_pins <= `AOFM_ZERO;
            chan_b_out_bus <= `AOFM_ZERO;
        end
        else
        begin
            // common out clock
            // the out clock is a register, so it never glitches
            hi_q <= ~hi_q;
            sample_out_clock <= ~hi_q;
            if (hi_q)
            begin
                if (mux_q)
                begin
                    chan_a_out_pins <= `AOFM_ZERO;
                    if (ph_q == `AOFM_PH_A)
                        chan_b_out_bus <= ff_valid ? ff_out[2*W-1:W] : chan_b_out_bus;
                    else
                        chan_b_out_bus <= ff_out[W-1:0];
                    if (ff_valid)
                        ph_q <= ~ph_q;
                    // leave only after B, or idle before A
                    if ((ph_q == `AOFM_PH_B) | ~ff_valid)
                        mux_q <= mux_req;
                end
                // normal mode: both buses carry their own channel
                else
                begin
                    // no data: hold, the receiver folds the repeat
                    if (ff_valid)
                    begin
                        chan_a_out_pins <= ff_out[2*W-1:W];
                        chan_b_out_bus <= ff_out[W-1:0];
                    end
                    ph_q <= `AOFM_PH_A;
                    mux_q <= mux_req;
                end
            end
        end
    end

    // all A pins always driven, never floated
    // a floating bus would let the receiver see noise
    assign chan_a_out_oe = {W{1'b1}};
endmodule

/* File: testbench/aofm_props.sv */
// timing checker on the block's output pins
// assumes bind to aofm_top, one clock
module aofm_props #(parameter W = 11, parameter DEPTH = 32) (
    input wire sys_clk,
    input wire rst_n,
    input wire samp_ready,
    input wire mux_reg_en,
    input wire [2:0] ctrl_pins,
    input wire [W-1:0] chan_a_out_pins,
    input wire [W-1:0] chan_a_out_oe,
    input wire [W-1:0] chan_b_out_bus,
    input wire sample_out_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_oe_high: assert property (&chan_a_out_oe)
        else $error("a pins released");
    chk_clk_pulse: assert property ($rose(sample_out_clock) |=> $fell(sample_out_clock))
        else $error("out clock high too long");
    chk_b_at_fall: assert property ($changed(chan_b_out_bus) |-> $fell(sample_out_clock))
        else $error("b bus moved off fall");
    chk_a_at_fall: assert property ($changed(chan_a_out_pins) |-> $fell(sample_out_clock))
        else $error("a pins moved off fall");
    chk_ready_back: assert property (!samp_ready |-> ##[1:6] samp_ready)
        else $error("fifo stuck full");
    chk_reset_zero: assert property ($rose(rst_n) |-> !chan_a_out_pins && !chan_b_out_bus)
        else $error("outputs not cleared");
    chk_reset_ready: assert property ($rose(rst_n) |=> samp_ready)
        else $error("not ready after reset");
    chk_a_zero_mux: assert property (mux_reg_en && $past(mux_reg_en, 8)
        |-> !chan_a_out_pins)
        else $error("a pins live in mux mode");
    cov_full: cover property (!samp_ready);
    cov_mux_reg: cover property (mux_reg_en && $fell(sample_out_clock));
    cov_mux_pins: cover property (&ctrl_pins && $fell(sample_out_clock));
endmodule
bind aofm_top aofm_props #(.W(W), .DEPTH(DEPTH)) i_props (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .samp_ready(samp_ready),
    .mux_reg_en(mux_reg_en),
    .ctrl_pins(ctrl_pins),
    .chan_a_out_pins(chan_a_out_pins),
    .chan_a_out_oe(chan_a_out_oe),
    .chan_b_out_bus(chan_b_out_bus),
    .sample_out_clock(sample_out_clock)
);

/* File: testbench/aofm_rx_model.sv */
// receiver model: latches one word per out clock rise
// assumes words stand still there; repeats fold into one
module aofm_rx_model #(parameter W = 11) (
    input wire sample_out_clock,
    input wire [W-1:0] chan_a_out_pins,
    input wire [W-1:0] chan_b_out_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2*W-1:0] got[$];
    logic [2*W-1:0] last_q = '0;
    always @(posedge sample_out_clock)
    begin
        if ({chan_a_out_pins, chan_b_out_bus} !== last_q)
            got.push_back({chan_a_out_pins, chan_b_out_bus});
        last_q = {chan_a_out_pins, chan_b_out_bus};
    end
endmodule

/* File: testbench/aofm_top_tb.sv */
// bench: random pairs in, receiver words compared
// assumes the receiver model and the bound checker
module aofm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst_n = 0, samp_valid = 0, mux_reg_en = 0;
    logic ovr_pos_a = 0, ovr_neg_a = 0, ovr_pos_b = 0, ovr_neg_b = 0;
    logic per_channel_code_format_a = 0, per_channel_code_format_b = 0;
    logic [2:0] ctrl_pins = 0;
    logic [10:0] raw_a = 0, raw_b = 0, chan_a_out_pins, chan_a_out_oe, chan_b_out_bus;
    logic samp_ready, sample_out_clock;
    logic [21:0] exp_q[$], prv = 0;
    logic [31:0] rng = 44907;
    int bad_count = 0, total_checks = 0, stalls = 0;
    aofm_top i_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .raw_a(raw_a),
        .ovr_pos_a(ovr_pos_a),
        .ovr_neg_a(ovr_neg_a),
        .raw_b(raw_b),
        .ovr_pos_b(ovr_pos_b),
        .ovr_neg_b(ovr_neg_b),
        .samp_valid(samp_valid),
        .samp_ready(samp_ready),
        .per_channel_code_format_a(per_channel_code_format_a),
        .per_channel_code_format_b(per_channel_code_format_b),
        .mux_reg_en(mux_reg_en),
        .ctrl_pins(ctrl_pins),
        .chan_a_out_pins(chan_a_out_pins),
        .chan_a_out_oe(chan_a_out_oe),
        .chan_b_out_bus(chan_b_out_bus),
        .sample_out_clock(sample_out_clock)
    );
    aofm_rx_model i_rx (
        .sample_out_clock(sample_out_clock),
        .chan_a_out_pins(chan_a_out_pins),
        .chan_b_out_bus(chan_b_out_bus)
    );
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [10:0] enc(logic [10:0] r, logic p, logic n, logic t);
        return p ? (t ? 11'h3FF : 11'h7FF) : n ? {t, 10'h000} : r ^ {t, 10'h000};
    endfunction
    // xorshift step for the random stimulus
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction
    task automatic check(input logic [21:0] e, input logic [21:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one pair offered; repeats against the last word are avoided
    task automatic push(input int gap);
        logic [10:0] ea, eb;
        logic m;
        int n;
        rng = xorshift(rng);
        m = mux_reg_en | &ctrl_pins;
        {per_channel_code_format_a, per_channel_code_format_b, raw_a} = rng[12:0];
        {ovr_pos_a, ovr_neg_b, ovr_neg_a, ovr_pos_b} =
            rng[15:14] ? 4'h0 : {rng[13], rng[13], !rng[13], !rng[13]};
        repeat (2)
        begin
            raw_b = raw_a ^ 11'h555;
            ea = enc(raw_a, ovr_pos_a, ovr_neg_a, per_channel_code_format_a);
            eb = enc(raw_b, ovr_pos_b, ovr_neg_b, per_channel_code_format_b);
            if ((m ? {11'h000, ea} : {ea, eb}) == prv)
                {ovr_pos_a, ovr_neg_a, ovr_pos_b, ovr_neg_b, raw_a} = {4'h0, ~raw_a};
        end
        if (m)
            exp_q.push_back({11'h000, ea});
        prv = m ? {11'h000, eb} : {ea, eb};
        exp_q.push_back(prv);
        samp_valid = 1;
        for (n = 0; !samp_ready && n < 200; n++)
        begin
            @(posedge sys_clk) #1;
            stalls++;
        end
        // a fifo that never drains is a mismatch
        if (!samp_ready)
        begin
            bad_count++;
            complete_run();
        end
        @(posedge sys_clk) #1;
        if (gap > 0)
            samp_valid = 0;
        repeat (gap) @(posedge sys_clk) #1;
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1;
        for (int p = 0; p < 3; p++)
        begin
            // field, then pins; 3'h6 selects nothing
            {mux_reg_en, ctrl_pins} = p == 0 ? 4'h6 : p == 1 ? 4'h8 : 4'h7;
            repeat (10) @(posedge sys_clk) #1;
            // entering mux drops the A pins, which the receiver sees once
            if ((mux_reg_en | &ctrl_pins) && prv[21:11] != 11'h000)
            begin
                prv = {11'h000, prv[10:0]};
                exp_q.push_back(prv);
            end
            // mux pairs paced at one per four sys_clk cycles, the same as the mux drain rate
            repeat (p ? 24 : 80) push(p ? 3 : 0);
            samp_valid = 0;
            repeat (3000) if (i_rx.got.size() < exp_q.size()) @(posedge sys_clk) #1;
            if (i_rx.got.size() < exp_q.size())
            begin
                bad_count++;
                complete_run();
            end
            while (exp_q.size())
                check(exp_q.pop_front(), i_rx.got.pop_front());
        end
        repeat (20) @(posedge sys_clk) #1;
        check(22'(stalls > 0), 22'h1);
        check(22'(i_rx.got.size()), 22'h0);
        complete_run();
    end
endmodule
